// file: core/topr_pkg.sv
// Shared constants and types for the timer output pin block
package topr_pkg;
  // Register byte offsets on the APB side
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_START = 8'h04;
  localparam logic [7:0] OFF_IOCTL = 8'h08;
  localparam logic [7:0] OFF_GRA = 8'h0C;
  localparam logic [7:0] OFF_GRB = 8'h10;
  localparam logic [7:0] OFF_GRC = 8'h14;
  localparam logic [7:0] OFF_GRD = 8'h18;
  localparam logic [7:0] OFF_COUNT = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;

  // Mode register field positions
  localparam int MODE_LSB = 0;
  localparam int CYC_LSB = 4;
  localparam int CLR_BIT = 6;
  localparam int BUFC_BIT = 8;
  localparam int BUFD_BIT = 9;

  // Pin control field: one nibble per pin, level bit above the action
  localparam int IO_FIELD_W = 4;
  localparam int IO_LEVEL_BIT = 2;

  // Values after reset
  localparam logic [3:0] PINS_RST = 4'h0;
  localparam logic [1:0] CYC_RST = 2'h0;

  // Operating modes; phase counting has four variants
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_PWM_ONE,
    MODE_PWM_TWO,
    MODE_PCM1,
    MODE_PCM2,
    MODE_PCM3,
    MODE_PCM4
  } topr_mode_t;

  // Highest legal mode code
  localparam logic [2:0] MODE_MAX = 3'h6;

  // Action taken by a pin on compare match
  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_LOW,
    ACT_HIGH,
    ACT_TOGGLE
  } topr_act_t;

  // Per-pin output control
  typedef struct packed {
    logic level;
    topr_act_t action;
  } topr_io_t;

  // Mode register contents
  typedef struct packed {
    logic bufD;
    logic bufC;
    logic clrEn;
    logic [1:0] cycleSel;
    topr_mode_t mode;
  } topr_cfg_t;
endpackage

// file: core/topr_timer_core.sv
// Overview of operation
// - Seven modes; any mode may follow any other.
// - Pin control write initialises selected pin levels.
// - Pulse mode one: B and D never initialised.
// - Pulse mode two: cycle pin never initialised.
// - Normal/mode two: buffered C/D pins not initialised.
// - Mode one: any C/D buffering blocks C init.
// - Reset leaves every timer output low.
// - Reset selects normal mode.
// - Initial high, low on match drives low.
// - Start bit runs counter; clearing it halts.
// - Reset and standby both drive pins low.
//
// The implementer's own choices: the APB slave port and the address map.
module topr_timer_core #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby,
  input wire logic phaseUp,
  input wire logic phaseDown,
  output logic [3:0] pinLevel,
  output logic running
);
  // Mode register and control
  topr_pkg::topr_cfg_t cfg;
  topr_pkg::topr_io_t ioCtl [4];
  logic [CNT_W-1:0] genReg [4];
  logic [CNT_W-1:0] count;

  // Decoded bus strobes
  logic access;
  logic wrEn;
  logic ioWr;
  logic cntWr;
  logic mapped;

  // Counter and pin helpers
  logic isPcm;
  logic tick;
  logic clearCnt;
  logic [3:0] match;
  logic [3:0] initOk;
  logic [3:0] next_pinLevel;
  logic [31:0] next_prdata;

  // Second edge of the access phase completes the transfer
  assign access = psel && penable && pready && ce;
  assign wrEn = access && pwrite;
  assign ioWr = wrEn && (paddr == topr_pkg::OFF_IOCTL);
  assign cntWr = wrEn && (paddr == topr_pkg::OFF_COUNT);

  // Address decode for the error answer
  always_comb begin
    if (paddr == topr_pkg::OFF_MODE) begin
      mapped = 1'b1;
    end else if (paddr == topr_pkg::OFF_START) begin
      mapped = 1'b1;
    end else if (paddr == topr_pkg::OFF_IOCTL) begin
      mapped = 1'b1;
    end else if (paddr >= topr_pkg::OFF_GRA && paddr <= topr_pkg::OFF_STATUS) begin
      mapped = (paddr[1:0] == 2'b00);
    end else begin
      mapped = 1'b0;
    end
  end

  // Phase counting ticks on each cycle with exactly one phase input high
  assign isPcm = cfg.mode >= topr_pkg::MODE_PCM1;
  assign tick = running && (!isPcm || (phaseUp ^ phaseDown));

  // Compare match only while the counter advances
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      match[i] = tick && (count == genReg[i]);
    end
  end

  // Counter clear on the cycle register in pulse modes, and in normal mode with clear enabled
  assign clearCnt = match[cfg.cycleSel] && !isPcm &&
                    (cfg.mode != topr_pkg::MODE_NORMAL || cfg.clrEn);

  // Pins that a pin control write may set in the current mode
  always_comb begin
    initOk = 4'hF;
    case (cfg.mode)
      topr_pkg::MODE_PWM_ONE: begin
        initOk[1] = 1'b0;
        initOk[3] = 1'b0;
        initOk[2] = !(cfg.bufC || cfg.bufD);
      end
      topr_pkg::MODE_PWM_TWO: begin
        initOk[cfg.cycleSel] = 1'b0;
        if (cfg.bufC) begin
          initOk[2] = 1'b0;
        end
        if (cfg.bufD) begin
          initOk[3] = 1'b0;
        end
      end
      topr_pkg::MODE_NORMAL: begin
        initOk[2] = !cfg.bufC;
        initOk[3] = !cfg.bufD;
      end
      default: begin
        initOk = 4'hF;
      end
    endcase
  end

  // Level after a match action
  function automatic logic applyAct(topr_pkg::topr_act_t act, logic cur);
    logic res;
    res = cur;
    case (act)
      topr_pkg::ACT_LOW: res = 1'b0;
      topr_pkg::ACT_HIGH: res = 1'b1;
      topr_pkg::ACT_TOGGLE: res = !cur;
      default: res = cur;
    endcase
    return res;
  endfunction

  // Next pin levels: waveform, then init write, then standby
  always_comb begin
    topr_pkg::topr_io_t newIo;
    newIo = '0;
    next_pinLevel = pinLevel;
    for (int i = 0; i < 4; i++) begin
      case (cfg.mode)
        topr_pkg::MODE_PWM_ONE: begin
          // Pairs A/B and C/D each shape one pin
          if ((i == 0 || i == 2) && initOk[i]) begin
            if (match[i]) begin
              next_pinLevel[i] = applyAct(ioCtl[i].action, next_pinLevel[i]);
            end
            if (match[i | 1]) begin
              next_pinLevel[i] = applyAct(ioCtl[i | 1].action, next_pinLevel[i]);
            end
          end
        end
        topr_pkg::MODE_PWM_TWO: begin
          // Cycle match returns every duty pin to its start level
          if (initOk[i]) begin
            if (match[i]) begin
              next_pinLevel[i] = applyAct(ioCtl[i].action, next_pinLevel[i]);
            end
            if (match[cfg.cycleSel]) begin
              next_pinLevel[i] = ioCtl[i].level;
            end
          end
        end
        default: begin
          if (initOk[i] && match[i]) begin
            next_pinLevel[i] = applyAct(ioCtl[i].action, next_pinLevel[i]);
          end
        end
      endcase
      newIo = topr_pkg::topr_io_t'(pwdata[i*topr_pkg::IO_FIELD_W +: 3]);
      // Write lands on the pin at once, counter state aside
      if (ioWr && initOk[i] && newIo.action != topr_pkg::ACT_NONE) begin
        next_pinLevel[i] = newIo.level;
      end
    end
    if (standby) begin
      next_pinLevel = 4'h0;
    end
  end

  // Pin output latch
  always_ff @(posedge clk) begin
    if (rst) begin
      pinLevel <= topr_pkg::PINS_RST;
    end else if (ce) begin
      pinLevel <= next_pinLevel;
    end
  end

  // Mode register; codes above the last mode are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.mode <= topr_pkg::MODE_NORMAL;
      cfg.cycleSel <= topr_pkg::CYC_RST;
      cfg.clrEn <= 1'b0;
      cfg.bufC <= 1'b0;
      cfg.bufD <= 1'b0;
    end else if (wrEn && paddr == topr_pkg::OFF_MODE) begin
      if (pwdata[topr_pkg::MODE_LSB +: 3] <= topr_pkg::MODE_MAX) begin
        cfg.mode <= topr_pkg::topr_mode_t'(pwdata[topr_pkg::MODE_LSB +: 3]);
      end
      cfg.cycleSel <= pwdata[topr_pkg::CYC_LSB +: 2];
      cfg.clrEn <= pwdata[topr_pkg::CLR_BIT];
      cfg.bufC <= pwdata[topr_pkg::BUFC_BIT];
      cfg.bufD <= pwdata[topr_pkg::BUFD_BIT];
    end
  end

  // Count start bit
  always_ff @(posedge clk) begin
    if (rst) begin
      running <= 1'b0;
    end else if (wrEn && paddr == topr_pkg::OFF_START) begin
      running <= pwdata[0];
    end
  end

  // Pin control register; fields kept even for blocked pins
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        ioCtl[i] <= '0;
      end
    end else if (ioWr) begin
      for (int i = 0; i < 4; i++) begin
        ioCtl[i] <= topr_pkg::topr_io_t'(pwdata[i*topr_pkg::IO_FIELD_W +: 3]);
      end
    end
  end

  // General registers with buffer transfer on A and B matches
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        genReg[i] <= '1;
      end
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        if (wrEn && paddr == topr_pkg::OFF_GRA + 8'(4 * i)) begin
          genReg[i] <= pwdata[CNT_W-1:0];
        end else if (i < 2 && match[i] && (i == 0 ? cfg.bufC : cfg.bufD)) begin
          genReg[i] <= genReg[i ^ 2];
        end
      end
    end
  end

  // Counter: bus write beats clear, clear beats counting
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (cntWr) begin
      count <= pwdata[CNT_W-1:0];
    end else if (ce && tick) begin
      if (clearCnt) begin
        count <= '0;
      end else if (isPcm && phaseDown) begin
        count <= count - 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  // Read data mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == topr_pkg::OFF_MODE) begin
      next_prdata = {22'h0, cfg.bufD, cfg.bufC, 1'b0, cfg.clrEn, cfg.cycleSel, 1'b0, cfg.mode};
    end else if (paddr == topr_pkg::OFF_START) begin
      next_prdata[0] = running;
    end else if (paddr == topr_pkg::OFF_IOCTL) begin
      for (int i = 0; i < 4; i++) begin
        next_prdata[i*topr_pkg::IO_FIELD_W +: 3] = ioCtl[i];
      end
    end else if (paddr == topr_pkg::OFF_COUNT) begin
      next_prdata[CNT_W-1:0] = count;
    end else if (paddr == topr_pkg::OFF_STATUS) begin
      next_prdata[3:0] = pinLevel;
    end else if (paddr >= topr_pkg::OFF_GRA && paddr <= topr_pkg::OFF_GRD) begin
      next_prdata[CNT_W-1:0] = genReg[2'(paddr[4:2] - 3'd3)];
    end
  end

  // APB answer one cycle into the access phase, one wait state
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  AST_RESET_LOW: assert property (@(posedge clk) rst |=> pinLevel == 4'h0)
    else $error("pins not low after reset");
  AST_RESET_MODE: assert property (@(posedge clk) rst |=> cfg.mode == topr_pkg::MODE_NORMAL)
    else $error("mode not normal after reset");
  AST_STANDBY_LOW: assert property (@(posedge clk) disable iff (rst)
    ce && standby |=> pinLevel == 4'h0)
    else $error("pins not low in standby");
  AST_INIT_NOW: assert property (@(posedge clk) disable iff (rst)
    ioWr && cfg.mode == topr_pkg::MODE_NORMAL && !standby && pwdata[1:0] != 2'b00
    |=> pinLevel[0] == $past(pwdata[2]) && ioCtl[0].level == pinLevel[0])
    else $error("pin A not initialised by write");
  AST_PULSE_WIDTH_MODE_ONE_BD_HOLD: assert property (@(posedge clk) disable iff (rst)
    ioWr && cfg.mode == topr_pkg::MODE_PWM_ONE && !standby
    |=> $stable(pinLevel[1]) && $stable(pinLevel[3]))
    else $error("pin B or D moved in pulse mode one");
  AST_PULSE_WIDTH_MODE_TWO_CYC_HOLD: assert property (@(posedge clk) disable iff (rst)
    ioWr && cfg.mode == topr_pkg::MODE_PWM_TWO && cfg.cycleSel == 2'h0 && !standby
    |=> $stable(pinLevel[0]))
    else $error("cycle pin moved in pulse mode two");
  AST_BUF_HOLD: assert property (@(posedge clk) disable iff (rst)
    ioWr && cfg.mode == topr_pkg::MODE_NORMAL && cfg.bufD && !standby && !match[3]
    |=> $stable(pinLevel[3]))
    else $error("buffered pin D initialised");
  AST_PULSE_WIDTH_MODE_ONE_C_HOLD: assert property (@(posedge clk) disable iff (rst)
    ioWr && cfg.mode == topr_pkg::MODE_PWM_ONE && (cfg.bufC || cfg.bufD) && !standby
    |=> $stable(pinLevel[2]))
    else $error("pin C initialised while buffered");
  AST_MATCH_LOW: assert property (@(posedge clk) disable iff (rst)
    ce && match[0] && cfg.mode == topr_pkg::MODE_NORMAL && !cfg.bufC
    && ioCtl[0].action == topr_pkg::ACT_LOW && !ioWr
    |=> pinLevel[0] == 1'b0)
    else $error("pin A not low after match");
  AST_COUNT_RUN: assert property (@(posedge clk) disable iff (rst)
    ce && running && cfg.mode == topr_pkg::MODE_NORMAL && !clearCnt && !cntWr
    ##1 !cntWr |-> count == $past(count, 1) + 1'b1)
    else $error("counter did not advance");
  AST_COUNT_HALT: assert property (@(posedge clk) disable iff (rst)
    !running && !cntWr |=> $stable(count))
    else $error("counter moved while stopped");
  AST_MODE_ANY: assert property (@(posedge clk) disable iff (rst)
    wrEn && paddr == topr_pkg::OFF_MODE && pwdata[2:0] <= topr_pkg::MODE_MAX
    |=> cfg.mode == $past(pwdata[2:0]))
    else $error("mode write not taken");
endmodule // topr_timer_core

// file: verif/timer_output_pin_recovery_tb_top.sv
module timer_output_pin_recovery_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Bench clock, reset and APB master signals
  logic clk = 1'b0;
  logic rst;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic standby;
  logic phaseUp;
  logic phaseDown;
  logic [3:0] pinLevel;
  logic running;
  // Result counters and cycle count for the hang limit
  int mismatches = 0;
  int numChecks = 0;
  int cycles = 0;
  // Scratch read values
  logic [31:0] r1;
  logic [31:0] r2;
  logic e1;
  int n;

  `define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR at %0t: got %0h expected %0h", $time, a, b); end end

  // 125 MHz
  always #4 clk = ~clk;

  topr_timer_core topr_timer_core_inst (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby(standby), .phaseUp(phaseUp), .phaseDown(phaseDown), .pinLevel(pinLevel),
    .running(running)
  );

  // Hang limit: whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  // Counts and verdict; the only place the run ends
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // Data and response taken at the completing edge only
    r = prdata;
    e = pslverr;
    if (k >= 50) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Plain write, response ignored
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b1, d, r, e);
  endtask

  // Read with expected data and error flag
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b0, 32'h0000_0000, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask

  // Pins sampled one settled cycle after the cause
  task automatic pins(input logic [3:0] x);
    @(posedge clk);
    #1;
    `CHK(pinLevel, x)
  endtask

  // Settled cycles until pin A shows the given level; bounded
  task automatic wait_pin_a(input logic v, output int c);
    c = 0;
    while (pinLevel[0] !== v && c < 100) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  // Mode word: mode, cycle select A, no clear, buffer bits
  function automatic logic [31:0] mw(input topr_pkg::topr_mode_t m, input logic bc,
                                     input logic bd);
    return {22'h00_0000, bd, bc, 5'h00, m};
  endfunction

  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    standby = 1'b0;
    phaseUp = 1'b0;
    phaseDown = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset state
    pins(4'h0);
    `CHK(running, 1'b0)
    rdc(topr_pkg::OFF_MODE, 32'h0000_0000, 1'b0);
    rdc(8'h40, 32'h0000_0000, 1'b1);
    $display("reset test done");
    // Normal mode: init high (nibble 5), low on match, then halt
    wr(topr_pkg::OFF_GRA, 32'h0000_0008);
    wr(topr_pkg::OFF_IOCTL, 32'h0000_5555);
    pins(4'hF);
    wr(topr_pkg::OFF_START, 32'h0000_0001);
    pins(4'hF);
    `CHK(running, 1'b1)
    wait_pin_a(1'b0, n);
    `CHK(pinLevel, 4'hE)
    `CHK(n > 3, 1'b1)
    // Error: pins already parked outside, so counting is stopped first
    wr(topr_pkg::OFF_START, 32'h0000_0000);
    xfer(topr_pkg::OFF_COUNT, 1'b0, 32'h0000_0000, r1, e1);
    xfer(topr_pkg::OFF_COUNT, 1'b0, 32'h0000_0000, r2, e1);
    `CHK(r2, r1)
    $display("match test done");
    // Same mode restart: reinitialise without mode write
    wr(topr_pkg::OFF_IOCTL, 32'h0000_5555);
    pins(4'hF);
    // Pulse mode one leaves B and D alone
    wr(topr_pkg::OFF_MODE, mw(topr_pkg::MODE_PWM_ONE, 1'b0, 1'b0));
    wr(topr_pkg::OFF_IOCTL, 32'h0000_2222);
    pins(4'hA);
    // Pulse mode two leaves the cycle pin (A) alone
    wr(topr_pkg::OFF_MODE, mw(topr_pkg::MODE_PWM_TWO, 1'b0, 1'b0));
    wr(topr_pkg::OFF_IOCTL, 32'h0000_5555);
    pins(4'hE);
    // Normal mode with C and D buffering
    wr(topr_pkg::OFF_MODE, mw(topr_pkg::MODE_NORMAL, 1'b1, 1'b1));
    rdc(topr_pkg::OFF_MODE, mw(topr_pkg::MODE_NORMAL, 1'b1, 1'b1), 1'b0);
    wr(topr_pkg::OFF_IOCTL, 32'h0000_2222);
    pins(4'hC);
    // Pulse mode one with D buffering blocks C as well
    wr(topr_pkg::OFF_MODE, mw(topr_pkg::MODE_NORMAL, 1'b0, 1'b0));
    wr(topr_pkg::OFF_IOCTL, 32'h0000_5555);
    pins(4'hF);
    wr(topr_pkg::OFF_MODE, mw(topr_pkg::MODE_PWM_ONE, 1'b0, 1'b1));
    wr(topr_pkg::OFF_IOCTL, 32'h0000_2222);
    pins(4'hE);
    $display("blocking test done");
    // Every mode reachable, each from the previous one
    for (int i = 0; i < 7; i++) begin
      wr(topr_pkg::OFF_MODE, {29'h0000_0000, i[2:0]});
      rdc(topr_pkg::OFF_MODE, {29'h0000_0000, i[2:0]}, 1'b0);
    end
    // Out-of-range code keeps the last phase mode
    wr(topr_pkg::OFF_MODE, 32'h0000_0007);
    rdc(topr_pkg::OFF_MODE, 32'h0000_0006, 1'b0);
    wr(topr_pkg::OFF_IOCTL, 32'h0000_2222);
    pins(4'h0);
    $display("mode test done");
    // Normal mode, clear on match A (cycle of four): pin A toggles every four
    wr(topr_pkg::OFF_MODE, 32'h0000_0040);
    wr(topr_pkg::OFF_GRA, 32'h0000_0003);
    wr(topr_pkg::OFF_COUNT, 32'h0000_0000);
    wr(topr_pkg::OFF_IOCTL, 32'h0000_0007);
    pins(4'h1);
    wr(topr_pkg::OFF_START, 32'h0000_0001);
    wait_pin_a(1'b0, n);
    `CHK(n, 4)
    wait_pin_a(1'b1, n);
    `CHK(n, 4)
    wr(topr_pkg::OFF_START, 32'h0000_0000);
    $display("clear test done");
    // Phase counting: counts only on ticks, then pin A falls
    wr(topr_pkg::OFF_MODE, mw(topr_pkg::MODE_PCM1, 1'b0, 1'b0));
    wr(topr_pkg::OFF_GRA, 32'h0000_0003);
    wr(topr_pkg::OFF_COUNT, 32'h0000_0000);
    wr(topr_pkg::OFF_IOCTL, 32'h0000_5555);
    wr(topr_pkg::OFF_START, 32'h0000_0001);
    repeat (5) @(posedge clk);
    pins(4'hF);
    @(posedge clk);
    phaseUp <= 1'b1;
    repeat (6) @(posedge clk);
    phaseUp <= 1'b0;
    pins(4'hE);
    // Two down ticks take six back to four
    @(posedge clk);
    phaseDown <= 1'b1;
    repeat (2) @(posedge clk);
    phaseDown <= 1'b0;
    wr(topr_pkg::OFF_START, 32'h0000_0000);
    rdc(topr_pkg::OFF_COUNT, 32'h0000_0004, 1'b0);
    $display("phase test done");
    // Standby forces pins low
    wr(topr_pkg::OFF_IOCTL, 32'h0000_5555);
    pins(4'hF);
    @(posedge clk);
    standby <= 1'b1;
    pins(4'h0);
    @(posedge clk);
    standby <= 1'b0;
    // Reset in mid-run clears pins, start bit and mode
    wr(topr_pkg::OFF_IOCTL, 32'h0000_5555);
    pins(4'hF);
    wr(topr_pkg::OFF_START, 32'h0000_0001);
    @(posedge clk);
    rst <= 1'b1;
    pins(4'h0);
    `CHK(running, 1'b0)
    @(posedge clk);
    rst <= 1'b0;
    rdc(topr_pkg::OFF_MODE, 32'h0000_0000, 1'b0);
    $display("standby and reset test done");
    give_verdict();
  end
endmodule // timer_output_pin_recovery_tb_top
